// ===== verilog/atsc_pkg.sv
// package for the converter trigger and sample control block
// assumes a single 250 MHz reference clock and a plain register port
`default_nettype none

package atsc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ATSC_OFS_CTRL3 = 8'h00;
  localparam logic [7:0] ATSC_OFS_ISTAT = 8'h04;
  localparam logic [7:0] ATSC_OFS_IMASK = 8'h08;

  // ----------------------------------------------------------------
  // field positions of converter_control_word_3
  // ----------------------------------------------------------------
  localparam int ATSC_POS_DIGEN_HI = 18;
  localparam int ATSC_POS_DIGEN_LO = 16;
  localparam int ATSC_POS_VREF_HI  = 15;
  localparam int ATSC_POS_VREF_LO  = 13;
  localparam int ATSC_POS_HOLD     = 12;
  localparam int ATSC_POS_UPDIE    = 11;
  localparam int ATSC_POS_UPDFLAG  = 10;
  localparam int ATSC_POS_MANUAL   = 9;
  localparam int ATSC_POS_REQ      = 8;
  localparam int ATSC_POS_SEL_HI   = 5;
  localparam int ATSC_POS_SEL_LO   = 0;
  localparam int ATSC_POS_EV_UPD   = 0;

  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam logic [31:0] ATSC_RST_CTRL3 = 32'h0000_0000;
  localparam logic [0:0]  ATSC_RST_IRQ   = 1'h0;
  localparam int          ATSC_NUM_CONV  = 3;
  localparam int          ATSC_ACQ_W     = 10;
  localparam int          ATSC_SEL_W     = 6;

  // reference source codes
  localparam logic [1:0] ATSC_SRC_RAIL = 2'h0;
  localparam logic [1:0] ATSC_SRC_EXT  = 2'h1;
  localparam logic [1:0] ATSC_SRC_INT  = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] dig_en;
    logic [2:0] vref_sel;
    logic       hold;
    logic       irq_en;
    logic       manual;
    logic       req;
    logic [5:0] sel;
  } atsc_ctrl_t;

  typedef struct packed {
    logic [1:0] pos;
    logic [1:0] neg;
  } atsc_vref_t;

  // reference pair table, code 0 gives both supply rails
  function automatic atsc_vref_t atsc_vref_lut(input logic [2:0] code);
    atsc_vref_t v;
    v = '{pos: ATSC_SRC_RAIL, neg: ATSC_SRC_RAIL};
    case (code)
      3'h1: v = '{pos: ATSC_SRC_EXT,  neg: ATSC_SRC_RAIL};
      3'h2: v = '{pos: ATSC_SRC_RAIL, neg: ATSC_SRC_EXT};
      3'h3: v = '{pos: ATSC_SRC_INT,  neg: ATSC_SRC_EXT};
      3'h4: v = '{pos: ATSC_SRC_INT,  neg: ATSC_SRC_INT};
      3'h5: v = '{pos: ATSC_SRC_INT,  neg: ATSC_SRC_EXT};
      3'h6: v = '{pos: ATSC_SRC_INT,  neg: ATSC_SRC_RAIL};
      3'h7: v = '{pos: ATSC_SRC_RAIL, neg: ATSC_SRC_INT};
      default: v = '{pos: ATSC_SRC_RAIL, neg: ATSC_SRC_RAIL};
    endcase
    return v;
  endfunction

endpackage : atsc_pkg

`default_nettype wire

// ===== verilog/atsc_sync.sv
// three-stage synchroniser for pin inputs
// assumes inputs are asynchronous to the clock; a change counts once
// the second and third stage agree
`default_nettype none

module atsc_sync
  import atsc_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  if (WIDTH < 1) begin : g_chk
    $error("atsc_sync: WIDTH must be at least 1");
  end

  // shift chain, the output takes bits on which stages two and three agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      o_sync <= '0;
    end else begin
      s1     <= i_async;
      s2     <= s1;
      s3     <= s2;
      o_sync <= (s2 & s3) | (o_sync & (s2 ^ s3));
    end
  end

endmodule // atsc_sync

`default_nettype wire

// ===== verilog/atsc_acq_timer.sv
// acquisition timer for the shared converter
// assumes start is a one-cycle pulse on the same clock
`default_nettype none

module atsc_acq_timer
  import atsc_pkg::*;
#(
  parameter int CW = ATSC_ACQ_W
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          i_start,
  input  wire logic [CW-1:0] i_count,
  output var  logic          o_track,
  output var  logic          o_done
);

  typedef enum logic [1:0] {
    ATSC_T_IDLE  = 2'b01,
    ATSC_T_TRACK = 2'b10
  } atsc_tstate_t;

  atsc_tstate_t state;
  logic [CW-1:0] cnt;

  if (CW < 1) begin : g_chk
    $error("atsc_acq_timer: CW must be at least 1");
  end

  // track for the programmed count plus one cycle, then pulse done
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state  <= ATSC_T_IDLE;
      cnt    <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ATSC_T_IDLE: begin
          if (i_start) begin
            cnt   <= i_count;
            state <= ATSC_T_TRACK;
          end
        end
        ATSC_T_TRACK: begin
          if (cnt == '0) begin
            o_done <= 1'b1;
            state  <= ATSC_T_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: state <= ATSC_T_IDLE;
      endcase
    end
  end

  assign o_track = (state == ATSC_T_TRACK);

endmodule // atsc_acq_timer

`default_nettype wire

// ===== verilog/atsc_top.sv
// converter trigger and sample control: control word 3, interrupt
// status and mask, trigger gating and the shared converter sampling
// assumes converter busy flags come from logic on the same clock and
// hardware triggers arrive from pins
//
// Chosen here: the register addresses and the plain strobed port.
`default_nettype none

// Summary of operation
// RL1: three converter digital enables, bits 18-16
// RL2: bits 15-13 select reference pair, 000 rails
// RL3: trigger hold blocks new conversion starts
// RL4: update interrupt only when enable bit set
// RL5: update flag set when held and idle
// RL6: manual sampling bit never self-clears
// RL7: manual sampling overrides acquisition count
// RL8: manual sampling drives shared converter only
// RL9: request bit converts selected input
// RL10: request bit clears next clock
// RL11: software clears manual before requesting
// RL12: software disables hardware trigger sources
// RL13: update flag zero otherwise, read-only
module atsc_top
  import atsc_pkg::*;
#(
  parameter int NCONV = ATSC_NUM_CONV,
  parameter int ACQW  = ATSC_ACQ_W
) (
  input  wire logic            I_REF_CLK,
  input  wire logic            I_RESET_N,
  input  wire logic [7:0]      I_ADDR,
  input  wire logic [31:0]     I_WDATA,
  input  wire logic            I_WR,
  input  wire logic            I_RD,
  output var  logic [31:0]     O_RDATA,
  input  wire logic [NCONV-1:0] I_HW_TRIG,
  input  wire logic [NCONV-1:0] I_CONV_BUSY,
  input  wire logic            I_SHARED_BUSY,
  input  wire logic [ACQW-1:0] I_ACQ_COUNT,
  output var  logic [NCONV-1:0] O_DIG_EN,
  output var  atsc_vref_t      O_VREF,
  output var  logic [NCONV-1:0] O_CONV_START,
  output var  logic            O_SHARED_TRACK,
  output var  logic            O_SHARED_CONV,
  output var  logic [5:0]      O_SOFT_SEL,
  output var  logic            O_IRQ
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NCONV != ATSC_NUM_CONV) begin : g_chk_n
    $error("atsc_top: NCONV must match the three enable bits");
  end
  if (ACQW < 1 || ACQW > 16) begin : g_chk_a
    $error("atsc_top: ACQW must be 1 to 16");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  atsc_ctrl_t       ctrl;
  atsc_ctrl_t       next_ctrl;
  logic             upd_flag;
  logic             next_upd_flag;
  logic [0:0]       istat;
  logic [0:0]       imask;
  logic             manual_used;
  logic [NCONV-1:0] trig_s;
  logic             acq_track;
  logic             acq_done;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire hit_ctrl = (I_ADDR == ATSC_OFS_CTRL3);
  wire hit_stat = (I_ADDR == ATSC_OFS_ISTAT);
  wire hit_mask = (I_ADDR == ATSC_OFS_IMASK);
  wire wr_ctrl  = I_WR && hit_ctrl;
  wire wr_stat  = I_WR && hit_stat;
  wire wr_mask  = I_WR && hit_mask;

  // write image of the control word, flag bit is not writable
  wire atsc_ctrl_t wr_img = '{
    dig_en:   I_WDATA[ATSC_POS_DIGEN_HI:ATSC_POS_DIGEN_LO],
    vref_sel: I_WDATA[ATSC_POS_VREF_HI:ATSC_POS_VREF_LO],
    hold:     I_WDATA[ATSC_POS_HOLD],
    irq_en:   I_WDATA[ATSC_POS_UPDIE],
    manual:   I_WDATA[ATSC_POS_MANUAL],
    req:      I_WDATA[ATSC_POS_REQ],
    sel:      I_WDATA[ATSC_POS_SEL_HI:ATSC_POS_SEL_LO]
  };

  // read image of the control word
  wire [31:0] rd_ctrl = {
    13'h0000,
    ctrl.dig_en,
    ctrl.vref_sel,
    ctrl.hold,
    ctrl.irq_en,
    upd_flag,
    ctrl.manual,
    ctrl.req,
    2'h0,
    ctrl.sel
  };

  // read selection, unmapped offsets read zero
  wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                       hit_stat ? {31'h0000_0000, istat} :
                       hit_mask ? {31'h0000_0000, imask} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // control word next value
  // ----------------------------------------------------------------
  // a written 1 in the request bit lives for exactly one clock
  assign next_ctrl = wr_ctrl ? wr_img
                             : '{dig_en:   ctrl.dig_en,
                                 vref_sel: ctrl.vref_sel,
                                 hold:     ctrl.hold,
                                 irq_en:   ctrl.irq_en,
                                 manual:   ctrl.manual,   // [RL6]
                                 req:      1'b0,          // [RL10]
                                 sel:      ctrl.sel};

  // update ready only while held and no converter busy
  wire any_busy = (|I_CONV_BUSY) || I_SHARED_BUSY;
  assign next_upd_flag = ctrl.hold && !any_busy;  // [RL5] [RL13]

  // update event, gated by the interrupt enable
  wire upd_event = next_upd_flag && !upd_flag && ctrl.irq_en;  // [RL4]

  // ----------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      ctrl     <= '{dig_en:   ATSC_RST_CTRL3[ATSC_POS_DIGEN_HI:ATSC_POS_DIGEN_LO],
                    vref_sel: ATSC_RST_CTRL3[ATSC_POS_VREF_HI:ATSC_POS_VREF_LO],
                    hold:     ATSC_RST_CTRL3[ATSC_POS_HOLD],
                    irq_en:   ATSC_RST_CTRL3[ATSC_POS_UPDIE],
                    manual:   ATSC_RST_CTRL3[ATSC_POS_MANUAL],
                    req:      ATSC_RST_CTRL3[ATSC_POS_REQ],
                    sel:      ATSC_RST_CTRL3[ATSC_POS_SEL_HI:ATSC_POS_SEL_LO]};
      upd_flag <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      upd_flag <= next_upd_flag;
    end
  end

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      istat <= ATSC_RST_IRQ;
      imask <= ATSC_RST_IRQ;
    end else begin
      istat <= (istat & ~(wr_stat ? I_WDATA[0:0] : 1'b0)) | upd_event;
      if (wr_mask) begin
        imask <= I_WDATA[0:0];
      end
    end
  end

  // interrupt level and read data, both registered
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      O_IRQ   <= 1'b0;
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_IRQ   <= |(istat & imask);
      O_RDATA <= I_RD ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // hardware triggers
  // ----------------------------------------------------------------
  atsc_sync #(
    .WIDTH (NCONV)
  ) u_trig_sync (
    .clk     (I_REF_CLK),
    .reset_n (I_RESET_N),
    .i_async (I_HW_TRIG),
    .o_sync  (trig_s)
  );

  // rising edge of each synchronised trigger
  logic [NCONV-1:0] trig_d;
  wire  [NCONV-1:0] trig_rise = trig_s & ~trig_d;

  // a trigger starts only an enabled converter and never while held
  wire [NCONV-1:0] next_conv_start =
    trig_rise & ctrl.dig_en & {NCONV{!ctrl.hold}};  // [RL3] [RL1]

  // ----------------------------------------------------------------
  // shared converter: software request and sampling
  // ----------------------------------------------------------------
  // a request is itself a trigger, so the hold blocks it too
  wire soft_go = ctrl.req && !ctrl.hold;  // [RL3] [RL9]

  // after manual sampling the input is already acquired: convert now
  wire soft_direct = soft_go && manual_used && !ctrl.manual;  // [RL11] [RL7]

  // otherwise sample for the programmed count first
  wire soft_timed = soft_go && !manual_used && !ctrl.manual;

  atsc_acq_timer #(
    .CW (ACQW)
  ) u_acq (
    .clk     (I_REF_CLK),
    .reset_n (I_RESET_N),
    .i_start (soft_timed),
    .i_count (I_ACQ_COUNT),
    .o_track (acq_track),
    .o_done  (acq_done)
  );

  // manual sampling wins and the count is ignored while it is set
  wire next_shared_track = ctrl.manual || (acq_track && !ctrl.manual);  // [RL7] [RL8]

  // conversion of the shared converter
  wire next_shared_conv = soft_direct || (acq_done && !ctrl.manual && !ctrl.hold);

  // remember that the current sample came from manual sampling
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      manual_used <= 1'b0;
    end else if (ctrl.manual) begin
      manual_used <= 1'b1;
    end else if (soft_go) begin
      manual_used <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      trig_d         <= '0;
      O_CONV_START   <= '0;
      O_DIG_EN       <= '0;
      O_VREF         <= atsc_vref_lut(3'h0);
      O_SHARED_TRACK <= 1'b0;
      O_SHARED_CONV  <= 1'b0;
      O_SOFT_SEL     <= '0;
    end else begin
      trig_d         <= trig_s;
      O_CONV_START   <= next_conv_start;
      O_DIG_EN       <= ctrl.dig_en;                  // [RL1]
      O_VREF         <= atsc_vref_lut(ctrl.vref_sel); // [RL2]
      O_SHARED_TRACK <= next_shared_track;
      O_SHARED_CONV  <= next_shared_conv;             // [RL9]
      if (soft_go) begin
        O_SOFT_SEL <= ctrl.sel;                       // [RL9]
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  sequence s_req_seen;
    ctrl.req && !ctrl.hold;
  endsequence

  sequence s_manual_then_clear;
    ctrl.manual ##1 !ctrl.manual;
  endsequence

  a_dig_en_follow: assert property ( // [RL1]
    ##1 O_DIG_EN == $past(ctrl.dig_en))
    else $error("digital enable output does not follow the control word");

  a_vref_rails: assert property ( // [RL2]
    ctrl.vref_sel == 3'h0 |=> O_VREF.pos == ATSC_SRC_RAIL && O_VREF.neg == ATSC_SRC_RAIL)
    else $error("code zero does not select both supply rails");

  a_hold_blocks_start: assert property ( // [RL3]
    ctrl.hold |=> O_CONV_START == '0 && !O_SHARED_CONV)
    else $error("a trigger passed while the hold was set");

  a_irq_enable_gate: assert property ( // [RL4]
    !ctrl.irq_en && !istat[0] && !wr_stat |=> !istat[0])
    else $error("update status set with its interrupt enable clear");

  a_irq_level: assert property ( // [RL4]
    istat[0] && imask[0] ##1 istat[0] |-> O_IRQ)
    else $error("interrupt output low with unmasked status set");

  a_flag_cause: assert property ( // [RL5]
    upd_flag |-> $past(ctrl.hold) && !$past(any_busy))
    else $error("update flag set without hold or with a busy converter");

  a_flag_clear: assert property ( // [RL13]
    !ctrl.hold || any_busy |=> !upd_flag)
    else $error("update flag stays set without hold");

  a_manual_kept: assert property ( // [RL6]
    ctrl.manual && !wr_ctrl |=> ctrl.manual)
    else $error("manual sampling bit changed without a write");

  a_manual_track: assert property ( // [RL7]
    ctrl.manual [*2] |-> O_SHARED_TRACK)
    else $error("shared sample and hold not sampling under manual control");

  a_req_self_clear: assert property ( // [RL10]
    ctrl.req && !wr_ctrl |=> !ctrl.req)
    else $error("request bit did not clear after one clock");

  a_soft_convert: assert property ( // [RL9]
    s_manual_then_clear ##[0:8] s_req_seen |=> O_SHARED_CONV)
    else $error("request after manual sampling did not start a conversion");

  a_start_enabled: assert property ( // [RL1]
    (O_CONV_START & ~O_DIG_EN) == '0)
    else $error("start pulse sent to a disabled converter");

  a_irq_clear: assert property ( // [RL4]
    !istat[0] |=> !O_IRQ)
    else $error("interrupt output high with status clear");

  a_flag_set: assert property ( // [RL5]
    ctrl.hold && !any_busy |=> upd_flag)
    else $error("update flag not set while held and idle");

  a_manual_no_conv: assert property ( // [RL7]
    ctrl.manual |=> !O_SHARED_CONV)
    else $error("shared conversion started during manual sampling");

  a_req_set: assert property ( // [RL9]
    wr_ctrl && I_WDATA[ATSC_POS_REQ] |=> ctrl.req)
    else $error("written request bit not taken");

  a_soft_sel_load: assert property ( // [RL9]
    soft_go |=> O_SOFT_SEL == $past(ctrl.sel))
    else $error("software input select not taken with the request");

endmodule // atsc_top

`default_nettype wire

// ===== tb/atsc_conv_model.sv
// behavioural model of the converter cores behind the control block
// assumes start pulses are one cycle long and share the block's clock
`default_nettype none

module atsc_conv_model #(
  parameter int FAST = 4,
  parameter int SLOW = 24
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       i_slow,
  input  wire logic [2:0] i_conv_start,
  input  wire logic       i_shared_conv,
  output var  logic [2:0] o_conv_busy,
  output var  logic       o_shared_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  int         cnt [4];
  logic [3:0] go;

  // starts of the three dedicated cores and the shared core
  assign go = {i_shared_conv, i_conv_start};

  // each core stays busy for a prompt or slow conversion time
  always_ff @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (!reset_n) cnt[k] <= 0;
      else if (go[k]) cnt[k] <= i_slow ? SLOW : FAST;
      else if (cnt[k] > 0) cnt[k] <= cnt[k] - 1;
    end
  end

  // busy levels seen by the block
  always_comb begin
    for (int k = 0; k < 3; k++) o_conv_busy[k] = (cnt[k] > 0);
    o_shared_busy = (cnt[3] > 0);
  end
endmodule // atsc_conv_model

`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the converter trigger and sample control
// assumes the converter core model and the design package are compiled first
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module testbench
  import atsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [31:0] VREF_TAB = 32'h289A_9140;
  localparam logic [31:0] HOLD     = 32'h0000_1000;
  localparam logic [31:0] IE       = 32'h0000_0800;
  localparam logic [31:0] MAN      = 32'h0000_0200;
  localparam logic [31:0] REQ      = 32'h0000_0100;

  logic        clk, rst_n, wr, rd, slow, shared_busy, shared_track, shared_conv, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, r;
  logic [2:0]  hw_trig, conv_busy, dig_en, conv_start, seen;
  logic [9:0]  acq;
  logic [5:0]  soft_sel;
  atsc_vref_t  vref;
  int          mismatches, checks_done, n_start, n_conv, n_track;

  // ----------------------------------------------------------------
  // design and converter cores
  // ----------------------------------------------------------------
  atsc_top u_dut (
    .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_HW_TRIG(hw_trig),
    .I_CONV_BUSY(conv_busy), .I_SHARED_BUSY(shared_busy), .I_ACQ_COUNT(acq),
    .O_DIG_EN(dig_en), .O_VREF(vref), .O_CONV_START(conv_start),
    .O_SHARED_TRACK(shared_track), .O_SHARED_CONV(shared_conv),
    .O_SOFT_SEL(soft_sel), .O_IRQ(irq)
  );

  atsc_conv_model u_model (
    .clk(clk), .reset_n(rst_n), .i_slow(slow), .i_conv_start(conv_start),
    .i_shared_conv(shared_conv), .o_conv_busy(conv_busy), .o_shared_busy(shared_busy)
  );

  // ----------------------------------------------------------------
  // clock, bus tasks and closing report
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // write then read back in the next cycle, strobes back to back
  task automatic wr_rd_reg(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  // counts start pulses and sampling cycles over a fixed window
  task automatic watch(input int n);
    n_start = 0;
    n_conv = 0;
    n_track = 0;
    seen = 3'h0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (conv_start !== 3'h0) n_start++;
      seen = seen | conv_start;
      if (shared_conv === 1'b1) n_conv++;
      if (shared_track === 1'b1) n_track++;
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    hw_trig = 3'h0;
    slow = 1'b0;
    acq = 10'h005;
    mismatches = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    rd_reg(ATSC_OFS_CTRL3, r);
    `CHK(r, 32'h0)
    rd_reg(ATSC_OFS_ISTAT, r);
    `CHK(r, 32'h0)
    rd_reg(ATSC_OFS_IMASK, r);
    `CHK(r, 32'h0)
    `CHK(vref, 4'h0)
    wr_reg(8'h0C, 32'hFFFF_FFFF);
    rd_reg(8'h0C, r);
    `CHK(r, 32'h0)
    rd_reg(ATSC_OFS_CTRL3, r);
    `CHK(r, 32'h0)
    // every reference code with a changing enable pattern
    for (int c = 0; c < 8; c++) begin
      wr_reg(ATSC_OFS_CTRL3, {13'h0, 3'(7 - c), 3'(c), 13'h0});
      rd_reg(ATSC_OFS_CTRL3, r);
      `CHK(r, {13'h0, 3'(7 - c), 3'(c), 13'h0})
      `CHK(dig_en, 3'(7 - c))
      `CHK(vref, VREF_TAB[4*c +: 4])
    end
    // triggers pass only to the enabled converter while not held
    slow <= 1'b1;
    wr_reg(ATSC_OFS_CTRL3, 32'h0001_0000);
    @(posedge clk);
    hw_trig <= 3'h3;
    watch(10);
    `CHK(seen, 3'h1)
    `CHK(n_start, 1)
    // held while converter 0 is still busy: no update flag yet
    wr_reg(ATSC_OFS_CTRL3, 32'h0001_0000 | HOLD | IE);
    wr_reg(ATSC_OFS_IMASK, 32'h1);
    rd_reg(ATSC_OFS_CTRL3, r);
    `CHK(r, 32'h0001_0000 | HOLD | IE)
    `CHK(irq, 1'b0)
    @(posedge clk);
    hw_trig <= 3'h0;
    repeat (5) @(posedge clk);
    hw_trig <= 3'h1;
    watch(30);
    `CHK(seen, 3'h0)
    rd_reg(ATSC_OFS_CTRL3, r);
    `CHK(r, 32'h0001_1C00)
    rd_reg(ATSC_OFS_ISTAT, r);
    `CHK(r, 32'h1)
    `CHK(irq, 1'b1)
    wr_reg(ATSC_OFS_ISTAT, 32'h1);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    // the flag cannot be written and drops with the hold
    wr_reg(ATSC_OFS_CTRL3, 32'h0000_0400);
    @(posedge clk);
    rd_reg(ATSC_OFS_CTRL3, r);
    `CHK(r, 32'h0)
    // without the enable bit the flag raises no event
    wr_reg(ATSC_OFS_CTRL3, HOLD);
    repeat (4) @(posedge clk);
    rd_reg(ATSC_OFS_CTRL3, r);
    `CHK(r, HOLD | 32'h400)
    rd_reg(ATSC_OFS_ISTAT, r);
    `CHK(r, 32'h0)
    // the mask gates the output only
    wr_reg(ATSC_OFS_CTRL3, 32'h0);
    wr_reg(ATSC_OFS_IMASK, 32'h0);
    wr_reg(ATSC_OFS_CTRL3, HOLD | IE);
    repeat (4) @(posedge clk);
    rd_reg(ATSC_OFS_ISTAT, r);
    `CHK(r, 32'h1)
    `CHK(irq, 1'b0)
    wr_reg(ATSC_OFS_IMASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'b1)
    wr_reg(ATSC_OFS_ISTAT, 32'h1);
    wr_reg(ATSC_OFS_CTRL3, 32'h0);
    // software sampling with hardware triggers quiet
    slow <= 1'b0;
    hw_trig <= 3'h0;
    wr_reg(ATSC_OFS_CTRL3, REQ | 32'h15);
    watch(20);
    `CHK(n_track, 6)
    `CHK(n_conv, 1)
    `CHK(soft_sel, 6'h15)
    `CHK(n_start, 0)
    // a held request converts nothing
    wr_reg(ATSC_OFS_CTRL3, HOLD | REQ | 32'h0A);
    watch(20);
    `CHK(n_conv, 0)
    `CHK(n_track, 0)
    `CHK(soft_sel, 6'h15)
    wr_reg(ATSC_OFS_CTRL3, 32'h0);
    // manual sampling holds on, ignores the count, only the shared core
    wr_reg(ATSC_OFS_CTRL3, MAN);
    watch(40);
    `CHK(n_track, 40)
    `CHK(n_conv, 0)
    `CHK(n_start, 0)
    // a request while manual sampling is still set starts nothing
    wr_reg(ATSC_OFS_CTRL3, MAN | REQ);
    watch(4);
    `CHK(n_conv, 0)
    `CHK(n_track, 4)
    rd_reg(ATSC_OFS_CTRL3, r);
    `CHK(r, MAN)
    // clear manual sampling first, then request
    wr_reg(ATSC_OFS_CTRL3, 32'h0);
    wr_rd_reg(ATSC_OFS_CTRL3, REQ | 32'h2A, r);
    `CHK(r, REQ | 32'h2A)
    `CHK(shared_conv, 1'b1)
    rd_reg(ATSC_OFS_CTRL3, r);
    `CHK(r, 32'h2A)
    `CHK(soft_sel, 6'h2A)
    `CHK(shared_track, 1'b0)
    finish_test();
  end
endmodule // testbench

`undef CHK
`default_nettype wire
